// File: hdl/spa_pkg.sv
`default_nettype none
package spa_pkg;
    localparam int N_EXT = 6;
    localparam int N_REQ = 7;
    localparam logic [7:0] CFG_OFFSET = 8'hdc;
    localparam logic [7:0] CFG_RESET = 8'h40;
    localparam int PARK_BIT = 7;
    localparam int BRIDGE_TIER_BIT = 6;
    localparam logic [2:0] BRIDGE_IDX = 3'h6;
    localparam logic [2:0] LO_SLOT = 3'h7;
    localparam logic [6:0] GNT_ONE = 7'h01;

    typedef enum logic [0:0] {
        ARB_GRANT = 1'b0,
        ARB_TURN = 1'b1
    } spa_state_t;

    typedef struct packed {
        spa_state_t st;
        logic [7:0] cfg;
        logic [7:0] rdata;
        logic [6:0] gnt;
        logic [2:0] owner;
        logic [2:0] pend;
        logic [2:0] hi_last;
        logic [2:0] lo_last;
    } spa_regs_t;
endpackage : spa_pkg
`default_nettype wire

// File: hdl/spa_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module spa_arbiter
    import spa_pkg::*;
(
    // Clock and resets
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_global_reset_input,
    input wire logic i_power_on_reset,
    // Secondary bus
    input wire logic [N_EXT-1:0] i_req_n,
    output logic [N_EXT-1:0] o_gnt_n,
    input wire logic i_frame_n,
    input wire logic i_irdy_n,
    // Bridge master
    input wire logic i_bridge_req,
    output logic o_bridge_gnt,
    // Configuration access
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [7:0] i_cfg_wdata,
    output logic [7:0] o_cfg_rdata
);

    // Bridge is request slot 6 in both rotations
    localparam spa_regs_t REGS_RESET = '{
        st: ARB_GRANT,
        cfg: CFG_RESET,
        rdata: 8'h00,
        gnt: 7'h00,
        owner: BRIDGE_IDX,
        pend: BRIDGE_IDX,
        hi_last: LO_SLOT,
        lo_last: BRIDGE_IDX
    };

    spa_regs_t regs_r;
    spa_regs_t regs_nxt;
    logic rst_any;
    logic bus_idle;
    logic [6:0] req;
    logic [6:0] tier;
    logic [6:0] hi_req;
    logic [6:0] lo_req;
    logic [3:0] hpick;
    logic [3:0] lpick;
    logic [2:0] winner;

    // Round robin: first set bit after last, wrapping
    function automatic logic [3:0] rr_pick(input logic [7:0] m, input logic [2:0] last);
        logic [3:0] res;
        logic [2:0] idx;
        res = 4'h0;
        for (int k = 8; k >= 1; k--) begin
            idx = last + 3'(k);
            if (m[idx]) begin
                res = {1'b1, idx};
            end
        end
        return res;
    endfunction : rr_pick

    // Only one offset is mapped; everything else reads zero
    function automatic logic cfg_hit(input logic [7:0] a);
        return a == CFG_OFFSET;
    endfunction : cfg_hit

    // Sources are ORed; each must be glitch free
    assign rst_any = i_rst | i_global_reset_input | i_power_on_reset;
    assign bus_idle = i_frame_n & i_irdy_n;
    assign req = {i_bridge_req, ~i_req_n};
    assign tier = {regs_r.cfg[BRIDGE_TIER_BIT], regs_r.cfg[N_EXT-1:0]};
    assign hi_req = req & tier;
    assign lo_req = req & ~tier;
    assign hpick = rr_pick({|lo_req, hi_req}, regs_r.hi_last);
    assign lpick = rr_pick({1'b0, lo_req}, regs_r.lo_last);

    always_comb begin
        if (hpick[3]) begin
            winner = (hpick[2:0] == LO_SLOT) ? lpick[2:0] : hpick[2:0];
        end else if (regs_r.cfg[PARK_BIT]) begin
            winner = BRIDGE_IDX;
        end else begin
            winner = regs_r.owner;
        end
    end

    always_comb begin
        regs_nxt = regs_r;
        regs_nxt.rdata = 8'h00;
        if (i_cfg_rd && cfg_hit(i_cfg_addr)) begin
            regs_nxt.rdata = regs_r.cfg;
        end
        if (i_cfg_wr && cfg_hit(i_cfg_addr)) begin
            regs_nxt.cfg = i_cfg_wdata;
        end
        unique case (regs_r.st)
            ARB_GRANT: begin
                // Grant moves only on idle bus, via one dead cycle
                if (bus_idle && regs_r.gnt != (GNT_ONE << winner)) begin
                    regs_nxt.gnt = 7'h00;
                    regs_nxt.pend = winner;
                    regs_nxt.st = ARB_TURN;
                end
            end
            ARB_TURN: begin
                regs_nxt.gnt = GNT_ONE << regs_r.pend;
                regs_nxt.owner = regs_r.pend;
                regs_nxt.st = ARB_GRANT;
                // Parking grants leave the rotation untouched
                if (req[regs_r.pend]) begin
                    if (tier[regs_r.pend]) begin
                        regs_nxt.hi_last = regs_r.pend;
                    end else begin
                        regs_nxt.hi_last = LO_SLOT;
                        regs_nxt.lo_last = regs_r.pend;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge rst_any) begin
        if (rst_any) begin
            regs_r <= REGS_RESET;
        end else begin
            regs_r <= regs_nxt;
        end
    end

    assign o_gnt_n = ~regs_r.gnt[N_EXT-1:0];
    assign o_bridge_gnt = regs_r.gnt[BRIDGE_IDX];
    assign o_cfg_rdata = regs_r.rdata;

    a_gnt_onehot: assert property (@(posedge i_ref_clk) disable iff (rst_any)
        $onehot0(regs_r.gnt)) else $error("more than one grant");

    a_grant_gap: assert property (@(posedge i_ref_clk) disable iff (rst_any)
        (regs_r.gnt != 7'h00 && $past(regs_r.gnt) != 7'h00) |-> regs_r.gnt == $past(regs_r.gnt))
        else $error("grant moved without dead cycle");

    a_busy_hold: assert property (@(posedge i_ref_clk) disable iff (rst_any)
        (regs_r.st == ARB_GRANT && !bus_idle) |=> regs_r.gnt == $past(regs_r.gnt))
        else $error("grant changed on busy bus");

    a_cfg_reset: assert property (@(posedge i_ref_clk)
        $fell(rst_any) |-> regs_r.cfg == CFG_RESET) else $error("control not at reset value");

    a_high_tier: assert property (@(posedge i_ref_clk) disable iff (rst_any)
        (regs_r.st == ARB_TURN && req[regs_r.pend] && tier[regs_r.pend])
        |=> regs_r.hi_last == $past(regs_r.pend)) else $error("high tier pointer not advanced");

    a_low_slot: assert property (@(posedge i_ref_clk) disable iff (rst_any)
        (regs_r.st == ARB_TURN && req[regs_r.pend] && !tier[regs_r.pend])
        |=> regs_r.hi_last == LO_SLOT && regs_r.lo_last == $past(regs_r.pend))
        else $error("low tier slot not recorded");

    a_park_bridge: assert property (@(posedge i_ref_clk) disable iff (rst_any)
        (regs_r.st == ARB_GRANT && bus_idle && req == 7'h00 && regs_r.cfg[PARK_BIT] && !o_bridge_gnt)
        |=> regs_r.st == ARB_TURN ##1 o_bridge_gnt) else $error("bus not parked on bridge");

    a_park_last: assert property (@(posedge i_ref_clk) disable iff (rst_any)
        (regs_r.st == ARB_GRANT && req == 7'h00 && !regs_r.cfg[PARK_BIT] && regs_r.gnt != 7'h00)
        |=> regs_r.gnt == $past(regs_r.gnt)) else $error("parked grant moved");

    a_cfg_write: assert property (@(posedge i_ref_clk) disable iff (rst_any)
        (i_cfg_wr && i_cfg_addr == CFG_OFFSET) ##1 (i_cfg_rd && i_cfg_addr == CFG_OFFSET && !i_cfg_wr)
        |=> o_cfg_rdata == $past(i_cfg_wdata, 2)) else $error("readback differs from write");

    a_unmapped_rd: assert property (@(posedge i_ref_clk) disable iff (rst_any)
        (i_cfg_addr != CFG_OFFSET) |=> o_cfg_rdata == 8'h00) else $error("unmapped read not zero");

    // Checks below watch state this block drives; the read data checks also sample i_cfg_rd and i_cfg_addr
    a_turn_dead: assert property (@(posedge i_ref_clk) disable iff (rst_any)
        regs_r.st == ARB_TURN |-> regs_r.gnt == 7'h00)
        else $error("grant present in turn cycle");

    a_turn_grant: assert property (@(posedge i_ref_clk) disable iff (rst_any)
        regs_r.st == ARB_TURN |=> regs_r.st == ARB_GRANT && regs_r.gnt != 7'h00)
        else $error("turn cycle gave no grant");

    a_gnt_from_turn: assert property (@(posedge i_ref_clk) disable iff (rst_any)
        (regs_r.gnt != $past(regs_r.gnt) && regs_r.gnt != 7'h00) |-> $past(regs_r.st) == ARB_TURN)
        else $error("grant raised outside turn");

    a_reset_idle: assert property (@(posedge i_ref_clk)
        $fell(rst_any) |-> regs_r.gnt == 7'h00 && regs_r.st == ARB_GRANT)
        else $error("grant state not cleared by reset");

    a_owner_match: assert property (@(posedge i_ref_clk) disable iff (rst_any)
        regs_r.gnt != 7'h00 |-> regs_r.gnt == (GNT_ONE << regs_r.owner))
        else $error("owner differs from grant");

    a_rdata_idle: assert property (@(posedge i_ref_clk) disable iff (rst_any)
        !(i_cfg_rd && cfg_hit(i_cfg_addr)) |=> o_cfg_rdata == 8'h00)
        else $error("read data outside read cycle");

    a_rdata_hit: assert property (@(posedge i_ref_clk) disable iff (rst_any)
        (i_cfg_rd && cfg_hit(i_cfg_addr)) |=> o_cfg_rdata == $past(regs_r.cfg))
        else $error("read data not control value");

    c_low_grant: cover property (@(posedge i_ref_clk) disable iff (rst_any)
        regs_r.st == ARB_TURN && req[regs_r.pend] && !tier[regs_r.pend]);
    c_park_bridge: cover property (@(posedge i_ref_clk) disable iff (rst_any)
        req == 7'h00 && o_bridge_gnt && regs_r.cfg[PARK_BIT]);
    c_handover: cover property (@(posedge i_ref_clk) disable iff (rst_any)
        regs_r.gnt != 7'h00 ##1 regs_r.gnt == 7'h00 ##1 regs_r.gnt != $past(regs_r.gnt, 2));
    c_cfg_write: cover property (@(posedge i_ref_clk) disable iff (rst_any)
        i_cfg_wr && i_cfg_addr == CFG_OFFSET);
    c_park_last: cover property (@(posedge i_ref_clk) disable iff (rst_any)
        req == 7'h00 && !regs_r.cfg[PARK_BIT] && regs_r.gnt != 7'h00 && !o_bridge_gnt);

endmodule : spa_arbiter
`default_nettype wire

// File: verif/spa_masters.sv
`timescale 1ns/1ps
`default_nettype none
// Secondary bus masters: one short transfer per grant, then a quiet gap
module spa_masters
    import spa_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [N_EXT-1:0] i_want,
    input wire logic [N_EXT-1:0] i_gnt_n,
    output logic [N_EXT-1:0] o_req_n,
    output logic o_frame_n,
    output logic o_irdy_n
);
    logic [2:0] ph_r;
    assign o_req_n = ~i_want;
    // Gap lets the arbiter move the grant before anyone samples it again
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ph_r <= 3'h0;
        end else if (ph_r != 3'h0 || (i_want & ~i_gnt_n) != 6'h00) begin
            ph_r <= ph_r + 3'h1;
        end
    end
    assign o_frame_n = ph_r != 3'h1;
    assign o_irdy_n = ph_r == 3'h0 || ph_r > 3'h2;
endmodule : spa_masters
`default_nettype wire

// File: verif/secondary_pci_arbiter_tiering_tb.sv
`timescale 1ns/1ps
`default_nettype none
module secondary_pci_arbiter_tiering_tb;
    import spa_pkg::*;
    logic clk = 0, rst = 1, global_reset_input = 0, por = 0, breq = 0, wr = 0, rd = 0, frame_n, irdy_n, bgnt;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
    logic [5:0] want = 6'h00, req_n, gnt_n;
    logic [6:0] g;
    int n_errors = 0, checked = 0;
    assign g = {bgnt, ~gnt_n};
    initial forever #50 clk = ~clk;
    spa_arbiter DUT (.i_ref_clk(clk), .i_rst(rst), .i_global_reset_input(global_reset_input), .i_power_on_reset(por),
        .i_req_n(req_n), .o_gnt_n(gnt_n), .i_frame_n(frame_n), .i_irdy_n(irdy_n), .i_bridge_req(breq),
        .o_bridge_gnt(bgnt), .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr), .i_cfg_wdata(wd), .o_cfg_rdata(rdata));
    spa_masters PM (.i_ref_clk(clk), .i_rst(rst), .i_want(want), .i_gnt_n(gnt_n), .o_req_n(req_n),
        .o_frame_n(frame_n), .o_irdy_n(irdy_n));
    task automatic wrap_up();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic cfg_w(logic [7:0] a, logic [7:0] d);
        @(posedge clk); wr <= 1; addr <= a; wd <= d;
        @(posedge clk); wr <= 0;
    endtask : cfg_w
    task automatic cfg_r(logic [7:0] a, output logic [7:0] d);
        @(posedge clk); rd <= 1; addr <= a;
        @(posedge clk); rd <= 0;
        #1 d = rdata;
    endtask : cfg_r
    task automatic cfg_wr_rd(logic [7:0] a, logic [7:0] wv, output logic [7:0] d);
        @(posedge clk); wr <= 1; addr <= a; wd <= wv;
        @(posedge clk); wr <= 0; rd <= 1;
        @(posedge clk); rd <= 0;
        #1 d = rdata;
    endtask : cfg_wr_rd
    task automatic pulse(int k);
        @(posedge clk); rst <= k == 0; global_reset_input <= k == 1; por <= k == 2;
        repeat (2) @(posedge clk);
        rst <= 0; global_reset_input <= 0; por <= 0;
    endtask : pulse
    // Waits for the next new owner; a stuck grant ends the run
    task automatic own(int e, inout logic [6:0] last);
        int i;
        for (i = 0; i < 60 && (g === 7'h00 || g === last); i++) begin
            @(posedge clk); #1;
        end
        if (i == 60) begin
            n_errors++;
            wrap_up();
        end
        chk("owner", {1'b0, GNT_ONE << e}, {1'b0, g});
        last = g;
    endtask : own
    task automatic t_regs();
        logic [7:0] d;
        for (int k = 0; k < 3; k++) begin
            cfg_w(8'hdc, 8'hff); cfg_r(8'hdc, d); chk("cfg_rw", 8'hff, d);
            pulse(k); cfg_r(8'hdc, d); chk("cfg_reset", 8'h40, d);
        end
        cfg_w(8'hdd, 8'hff); cfg_r(8'hdd, d); chk("unmapped", 8'h00, d);
        cfg_r(8'hdc, d); chk("cfg_kept", 8'h40, d);
        cfg_wr_rd(8'hdc, 8'h5a, d); chk("cfg_b2b", 8'h5a, d);
        cfg_w(8'hdc, 8'h40);
        $display("test regs done");
    endtask : t_regs
    // Six owners expected in order, lowest field first
    task automatic t_seq(logic [7:0] c, logic br, logic [5:0] w, logic [17:0] ex);
        logic [6:0] last;
        pulse(0); cfg_w(8'hdc, c);
        last = 7'h40; breq <= br; want <= w;
        for (int j = 0; j < 6; j++) own(ex[3*j +: 3], last);
        @(posedge clk); want <= 0; breq <= 0;
        $display("test sequence %h done", c);
    endtask : t_seq
    task automatic t_park();
        logic [6:0] last;
        pulse(0); cfg_w(8'hdc, 8'h81);
        last = 7'h40; want <= 6'h01;
        own(0, last);
        @(posedge clk); want <= 6'h00;
        own(6, last);
        cfg_w(8'hdc, 8'h01); want <= 6'h02;
        own(1, last);
        @(posedge clk); want <= 6'h00;
        repeat (20) @(posedge clk);
        #1 chk("park_last", 8'h02, {1'b0, g});
        $display("test park done");
    endtask : t_park
    initial begin
        repeat (2) @(posedge clk);
        rst <= 0;
        t_regs();
        t_seq(8'h7f, 1, 6'h3c, {3'd2, 3'd6, 3'd5, 3'd4, 3'd3, 3'd2});
        t_seq(8'h43, 0, 6'h0f, {3'd3, 3'd1, 3'd0, 3'd2, 3'd1, 3'd0});
        t_seq(8'h01, 1, 6'h03, {3'd1, 3'd0, 3'd6, 3'd0, 3'd1, 3'd0});
        t_park();
        wrap_up();
    end
endmodule : secondary_pci_arbiter_tiering_tb
`default_nettype wire
